// [logic/pmrw_pkg.sv]
package pmrw_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MAIN_MAIN_CRYSTAL_KHZ = 24_000;
    localparam int unsigned WDT_IRQ_S = 2;
    localparam int unsigned WDT_RST_S = 4;
    localparam int unsigned WDT_IRQ_CYC = WDT_IRQ_S * CLK_HZ;
    localparam int unsigned WDT_RST_CYC = WDT_RST_S * CLK_HZ;
    localparam int unsigned REG_SETTLE_US = 100;
    localparam int unsigned REG_SETTLE_CYC = REG_SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned HCLK_DIV_ACTIVE = 1;
    localparam int unsigned HCLK_DIV_IDLE = 8;
    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [2:0] {
        PMRW_MODE_ACTIVE = 3'h0,
        PMRW_MODE_IDLE = 3'h1,
        PMRW_MODE_SLEEP = 3'h2,
        PMRW_MODE_PDS = 3'h3,
        PMRW_MODE_EXTENDED_POWER_DOWN_SLEEP = 3'h4,
        PMRW_MODE_OFF = 3'h5
    } pmrw_mode_t;
    typedef enum logic [1:0] {
        PMRW_LF_LOWPWR = 2'h0,
        PMRW_LF_ACCURATE = 2'h1,
        PMRW_LF_EXTXTAL = 2'h2
    } pmrw_lfsel_t;
    localparam logic [1:0] WAKE_NONE = 2'h0;
    localparam logic [1:0] WAKE_TIMER = 2'h1;
    localparam logic [1:0] WAKE_IO = 2'h2;
    localparam logic [1:0] WAKE_WDT = 2'h3;
endpackage

// [logic/pmrw_div.sv]
`timescale 1ns/1ps
module pmrw_div #(
    parameter int unsigned WIDTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic enable,
    input wire logic [WIDTH-1:0] limit,
    output logic tick
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    always_comb begin
        next_count = count;
        if (!enable || count + WIDTH'(1) >= limit) begin
            next_count = '0;
        end else begin
            next_count = count + WIDTH'(1);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
    assign tick = enable && (count + WIDTH'(1) >= limit);
endmodule

// [logic/pmrw_top.sv]
`timescale 1ns/1ps
// Overview of operation
// - Active mode runs the processor and enables every peripheral.
// - Idle mode pauses processor, bus clock slowed, other clocks on, state kept.
// - Bus clock is derived from the 24 MHz main crystal.
// - Sleep stops bus clock, keeps only slow clock, retains state at low voltage.
// - Sleep wakes on programmed interval expiry or an I/O event.
// - Power-down-sleep cuts radio and most core, keeps RAM and registers; same wakes.
// - Extended power-down-sleep keeps only main RAM and mode control; same wakes.
// - Deep-off powers down core, radio, regulators, slow oscillator and clock.
// - Waking from deep-off reinitialises fully, keeping deep-off flag and cause.
// - Mode changes happen only on firmware request, a wake event or the watchdog.
// - Watchdog interrupts firmware after 2 s without service.
// - Watchdog resets the device after 4 s without service.
// - Firmware selects slow clock from two internal oscillators or external crystal.
// - External slow input accepts 32 kHz, 32.768 kHz crystal or driven clock.
// - After battery present and reset off, buck first, then RF and digital regulators.
// - Core stays in reset until regulator outputs are stable.
// - External reset is honoured at any time after power-up.
// - Debug access to flash and RAM is off after power-up.
// - Lockout keeps debug access off and rejects raw memory read commands.
module pmrw_top #(
    parameter int unsigned WDT_IRQ_CYCLES = pmrw_pkg::WDT_IRQ_CYC,
    parameter int unsigned WDT_RST_CYCLES = pmrw_pkg::WDT_RST_CYC,
    parameter int unsigned SETTLE_CYCLES = pmrw_pkg::REG_SETTLE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic battery_ok,
    input wire logic ext_reset_n,
    input wire logic buck_good,
    input wire logic ldo_good,
    input wire logic [2:0] mode_req,
    input wire logic mode_req_valid,
    input wire logic [7:0] wake_interval,
    input wire logic io_wake,
    input wire logic wdt_service,
    input wire logic wdt_irq_clear,
    input wire logic [1:0] lf_select,
    input wire logic lf_lowpwr_clk,
    input wire logic lf_accurate_clk,
    input wire logic lf_extxtal_clk,
    input wire logic fw_debug_enable,
    input wire logic lockout_present,
    input wire logic raw_read_req,
    output logic [2:0] mode,
    output logic cpu_run,
    output logic periph_en,
    output logic hclk_en,
    output logic radio_pwr,
    output logic core_pwr,
    output logic retain_pwr,
    output logic ldo_low_v,
    output logic low_freq_clock,
    output logic lf_osc_en,
    output logic buck_en,
    output logic rf_ldo_en,
    output logic dig_ldo_en,
    output logic core_reset,
    output logic wdt_irq,
    output logic wdt_reset,
    output logic debug_access,
    output logic raw_read_grant,
    output logic raw_read_reject,
    output logic [1:0] wake_cause,
    output logic woke_from_off
);
    // ****************************************
    // Power-up sequencing
    // ****************************************
    typedef enum logic [2:0] {PMRW_SEQ_OFF, PMRW_SEQ_BUCK, PMRW_SEQ_LDO, PMRW_SEQ_SETTLE, PMRW_SEQ_RUN} pmrw_seq_t;
    pmrw_seq_t seq, next_seq;
    logic [31:0] settle, next_settle;
    logic hold_reset;
    logic wdt_fire;
    logic off_hold;
    // External reset or watchdog restart sequencing; deep-off drops every regulator
    assign hold_reset = !ext_reset_n || !battery_ok || wdt_fire || off_hold;
    always_comb begin
        next_seq = seq;
        next_settle = settle;
        unique case (seq)
            PMRW_SEQ_OFF: if (!hold_reset) next_seq = PMRW_SEQ_BUCK;
            PMRW_SEQ_BUCK: if (buck_good) next_seq = PMRW_SEQ_LDO;
            PMRW_SEQ_LDO: begin
                next_settle = '0;
                if (ldo_good) next_seq = PMRW_SEQ_SETTLE;
            end
            PMRW_SEQ_SETTLE: begin
                // Margin after good flags, they are comparators and can chatter
                next_settle = settle + 32'h1;
                if (!ldo_good) next_seq = PMRW_SEQ_LDO;
                else if (settle + 32'h1 >= SETTLE_CYCLES) next_seq = PMRW_SEQ_RUN;
            end
            PMRW_SEQ_RUN: ;
        endcase
        if (hold_reset) next_seq = PMRW_SEQ_OFF;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq <= PMRW_SEQ_OFF;
            settle <= '0;
        end else begin
            seq <= next_seq;
            settle <= next_settle;
        end
    end
    assign buck_en = seq != PMRW_SEQ_OFF;
    assign rf_ldo_en = seq inside {PMRW_SEQ_LDO, PMRW_SEQ_SETTLE, PMRW_SEQ_RUN};
    assign dig_ldo_en = rf_ldo_en;
    assign core_reset = seq != PMRW_SEQ_RUN;
    // ****************************************
    // Slow clock selection and sync
    // ****************************************
    logic lf_raw;
    logic [2:0] lf_sync, next_lf_sync;
    logic [1:0] io_sync, next_io_sync;
    logic io_lf, next_io_lf;
    logic lf_rise;
    always_comb begin
        // Any of the three sources, 32 or 32.768 kHz alike
        unique case (lf_select)
            pmrw_pkg::PMRW_LF_ACCURATE: lf_raw = lf_accurate_clk;
            pmrw_pkg::PMRW_LF_EXTXTAL: lf_raw = lf_extxtal_clk;
            default: lf_raw = lf_lowpwr_clk;
        endcase
        next_lf_sync = {lf_sync[1:0], lf_raw};
        next_io_sync = {io_sync[0], io_wake};
        next_io_lf = lf_rise ? io_sync[1] : io_lf;
    end
    assign lf_rise = lf_sync[1] && !lf_sync[2];
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lf_sync <= 3'h0;
            io_sync <= 2'h0;
            io_lf <= 1'b0;
        end else begin
            lf_sync <= next_lf_sync;
            io_sync <= next_io_sync;
            io_lf <= next_io_lf;
        end
    end
    assign low_freq_clock = lf_sync[1];
    // ****************************************
    // Power modes
    // ****************************************
    pmrw_pkg::pmrw_mode_t pm, next_pm;
    logic [7:0] wake_cnt, next_wake_cnt;
    logic [1:0] next_cause;
    logic next_off_flag;
    logic asleep, timer_wake;
    assign asleep = pm inside {pmrw_pkg::PMRW_MODE_SLEEP, pmrw_pkg::PMRW_MODE_PDS,
                               pmrw_pkg::PMRW_MODE_EXTENDED_POWER_DOWN_SLEEP, pmrw_pkg::PMRW_MODE_OFF};
    assign timer_wake = asleep && lf_rise && wake_cnt + 8'h1 >= wake_interval;
    logic off_wake;
    // Internal slow oscillators stop in deep-off, so the pin synchroniser wakes it without a slow edge
    assign off_wake = pm == pmrw_pkg::PMRW_MODE_OFF && io_sync[1];
    assign off_hold = pm == pmrw_pkg::PMRW_MODE_OFF;
    always_comb begin
        next_pm = pm;
        next_wake_cnt = wake_cnt;
        next_cause = wake_cause;
        next_off_flag = woke_from_off;
        if (mode_req_valid && !asleep && mode_req <= 3'(pmrw_pkg::PMRW_MODE_OFF)) begin
            next_pm = pmrw_pkg::pmrw_mode_t'(mode_req);
            next_wake_cnt = 8'h0;
        end else if (asleep) begin
            if (lf_rise) next_wake_cnt = wake_cnt + 8'h1;
            if (io_lf || timer_wake || off_wake) begin
                next_pm = pmrw_pkg::PMRW_MODE_ACTIVE;
                next_cause = (io_lf || off_wake) ? pmrw_pkg::WAKE_IO : pmrw_pkg::WAKE_TIMER;
                next_off_flag = pm == pmrw_pkg::PMRW_MODE_OFF;
            end
        end
        if (wdt_fire) begin
            next_pm = pmrw_pkg::PMRW_MODE_ACTIVE;
            next_cause = pmrw_pkg::WAKE_WDT;
            next_off_flag = 1'b0;
        end
    end
    // Cause and deep-off flag sit outside the core reset, as retained state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pm <= pmrw_pkg::PMRW_MODE_ACTIVE;
            wake_cnt <= 8'h0;
            wake_cause <= pmrw_pkg::WAKE_NONE;
            woke_from_off <= 1'b0;
        end else begin
            pm <= next_pm;
            wake_cnt <= next_wake_cnt;
            wake_cause <= next_cause;
            woke_from_off <= next_off_flag;
        end
    end
    assign mode = pm;
    logic hclk_tick;
    logic [3:0] hdiv;
    assign hdiv = pm == pmrw_pkg::PMRW_MODE_IDLE ? 4'(pmrw_pkg::HCLK_DIV_IDLE) : 4'(pmrw_pkg::HCLK_DIV_ACTIVE);
    // Bus clock enable, one-cycle pulses standing for the crystal-derived clock
    pmrw_div #(.WIDTH(4)) u_hclk (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable(!asleep && !core_reset),
        .limit(hdiv),
        .tick(hclk_tick)
    );
    assign hclk_en = hclk_tick;
    assign cpu_run = !core_reset && pm == pmrw_pkg::PMRW_MODE_ACTIVE;
    assign periph_en = !core_reset && pm inside {pmrw_pkg::PMRW_MODE_ACTIVE, pmrw_pkg::PMRW_MODE_IDLE};
    assign ldo_low_v = pm == pmrw_pkg::PMRW_MODE_SLEEP;
    assign radio_pwr = pm inside {pmrw_pkg::PMRW_MODE_ACTIVE, pmrw_pkg::PMRW_MODE_IDLE,
                                  pmrw_pkg::PMRW_MODE_SLEEP};
    assign core_pwr = radio_pwr;
    assign retain_pwr = pm != pmrw_pkg::PMRW_MODE_OFF;
    assign lf_osc_en = pm != pmrw_pkg::PMRW_MODE_OFF;
    // ****************************************
    // Watchdog
    // ****************************************
    logic [31:0] wdt_cnt, next_wdt_cnt;
    logic next_irq;
    always_comb begin
        next_wdt_cnt = wdt_cnt + 32'h1;
        next_irq = wdt_irq;
        if (wdt_service || core_reset || wdt_fire) next_wdt_cnt = '0;
        if (wdt_irq_clear) next_irq = 1'b0;
        if (!wdt_service && !core_reset && wdt_cnt + 32'h1 == WDT_IRQ_CYCLES) next_irq = 1'b1;
        if (core_reset) next_irq = 1'b0;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wdt_cnt <= '0;
            wdt_irq <= 1'b0;
        end else begin
            wdt_cnt <= next_wdt_cnt;
            wdt_irq <= next_irq;
        end
    end
    assign wdt_fire = !core_reset && !wdt_service && wdt_cnt + 32'h1 >= WDT_RST_CYCLES;
    assign wdt_reset = wdt_fire;
    // ****************************************
    // Debug lockout
    // ****************************************
    logic dbg, next_dbg;
    always_comb begin
        next_dbg = dbg;
        if (core_reset) next_dbg = 1'b0;
        else if (lockout_present) next_dbg = 1'b0;
        else if (fw_debug_enable) next_dbg = 1'b1;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dbg <= 1'b0;
        end else begin
            dbg <= next_dbg;
        end
    end
    assign debug_access = dbg && !lockout_present;
    assign raw_read_grant = raw_read_req && !lockout_present && !core_reset;
    assign raw_read_reject = raw_read_req && (lockout_present || core_reset);
    // ****************************************
    // Checks
    // ****************************************
    sequence s_ldo_up;
        seq == PMRW_SEQ_LDO ##1 seq == PMRW_SEQ_SETTLE;
    endsequence
    AST_CORE_AFTER_SETTLE: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(core_reset) |-> $past(seq) == PMRW_SEQ_SETTLE && $past(ldo_good))
        else $error("core left reset before regulators settled");
    AST_BUCK_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(rf_ldo_en) |-> $past(buck_en) && $past(buck_good))
        else $error("ldo enabled before buck");
    AST_EXT_RESET: assert property (@(posedge clk_sys) disable iff (rst)
        !ext_reset_n |=> core_reset && !buck_en)
        else $error("external reset not honoured");
    AST_WDT_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
        !core_reset && !wdt_service && !wdt_irq_clear && wdt_cnt + 32'h1 == WDT_IRQ_CYCLES |=> wdt_irq)
        else $error("watchdog interrupt missed");
    AST_WDT_RESET: assert property (@(posedge clk_sys) disable iff (rst)
        wdt_reset |=> core_reset && wdt_cnt == 32'h0)
        else $error("watchdog reset missed");
    AST_WDT_SERVICE: assert property (@(posedge clk_sys) disable iff (rst)
        wdt_service |=> wdt_cnt == 32'h0 && !wdt_reset)
        else $error("service did not restart watchdog");
    AST_DEBUG_LOCK: assert property (@(posedge clk_sys) disable iff (rst)
        lockout_present |-> !debug_access && !raw_read_grant)
        else $error("debug open under lockout");
    AST_DEBUG_RESET: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(core_reset) |-> !debug_access)
        else $error("debug open at power-up");
    AST_OFF_POWER: assert property (@(posedge clk_sys) disable iff (rst)
        mode == 3'(pmrw_pkg::PMRW_MODE_OFF) |-> !core_pwr && !lf_osc_en && !radio_pwr)
        else $error("deep-off left domains powered");
    AST_IO_WAKE: assert property (@(posedge clk_sys) disable iff (rst || wdt_fire)
        asleep && io_lf |=> mode == 3'(pmrw_pkg::PMRW_MODE_ACTIVE) && wake_cause == pmrw_pkg::WAKE_IO)
        else $error("io wake not taken");
    AST_SLEEP_CLK: assert property (@(posedge clk_sys) disable iff (rst)
        asleep |-> !hclk_en && !cpu_run)
        else $error("bus clock runs in sleep");
    AST_SEQ_ORDER: assert property (@(posedge clk_sys) disable iff (rst)
        s_ldo_up |-> buck_en && rf_ldo_en)
        else $error("regulator order broken");
endmodule

// [tb/pmrw_partner.sv]
`timescale 1ns/1ps
module pmrw_partner #(
    parameter int unsigned GOOD_DLY = 3
) (
    input wire logic clk_sys,
    input wire logic buck_en,
    input wire logic rf_ldo_en,
    input wire logic dig_ldo_en,
    input wire logic lf_osc_en,
    output logic buck_good,
    output logic ldo_good,
    output logic lf_lowpwr_clk,
    output logic lf_accurate_clk,
    output logic lf_extxtal_clk
);
    // ****************************************
    // Regulators
    // ****************************************
    int bcnt = 0;
    int lcnt = 0;
    always @(posedge clk_sys) begin
        bcnt <= buck_en ? bcnt + 1 : 0;
        lcnt <= (rf_ldo_en && dig_ldo_en) ? lcnt + 1 : 0;
    end
    // Good drops at once when disabled, no kinder than a real output
    assign buck_good = buck_en && (bcnt >= GOOD_DLY);
    assign ldo_good = rf_ldo_en && dig_ldo_en && (lcnt >= GOOD_DLY);
    // ****************************************
    // Slow oscillators, internal ones stop when disabled
    // ****************************************
    initial begin
        lf_lowpwr_clk = 1'b0;
        lf_accurate_clk = 1'b0;
        lf_extxtal_clk = 1'b0;
    end
    always #40 lf_lowpwr_clk = (lf_osc_en === 1'b1) ? ~lf_lowpwr_clk : 1'b0;
    always #60 lf_accurate_clk = (lf_osc_en === 1'b1) ? ~lf_accurate_clk : 1'b0;
    always #100 lf_extxtal_clk = ~lf_extxtal_clk;
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
    localparam int WIRQ = 200;
    localparam int WRST = 400;
    localparam int SETL = 4;
    logic clk_sys = 1'b0, rst = 1'b1, battery_ok = 1'b0, ext_reset_n = 1'b0, buck_good, ldo_good;
    logic [2:0] mode_req = 3'h0;
    logic mode_req_valid = 1'b0, io_wake = 1'b0, wdt_service = 1'b0, wdt_irq_clear = 1'b0;
    logic [7:0] wake_interval = 8'hff;
    logic [1:0] lf_select = 2'h0;
    logic lf_lowpwr_clk, lf_accurate_clk, lf_extxtal_clk;
    logic fw_debug_enable = 1'b0, lockout_present = 1'b0, raw_read_req = 1'b0;
    logic [2:0] mode;
    logic cpu_run, periph_en, hclk_en, radio_pwr, core_pwr, retain_pwr, ldo_low_v, low_freq_clock, lf_osc_en;
    logic buck_en, rf_ldo_en, dig_ldo_en, core_reset, wdt_irq, wdt_reset, debug_access;
    logic raw_read_grant, raw_read_reject, woke_from_off;
    logic [1:0] wake_cause;
    int num_errors = 0, compares = 0, exp_mode = 0, cyc = 0, lgc = 0, n, n2, iv;
    int seed = 32'h9fa9663c;
    bit svc_en = 1, svc_now = 0;
    int edges[$] = '{30, 20, 12};
    // Expected power bits {cpu, periph, radio, core, retain, low_v, lf_osc} and care masks
    logic [6:0] pexp[6] = '{7'h79, 7'h29, 7'h0f, 7'h05, 7'h05, 7'h00};
    logic [6:0] pmsk[6] = '{7'h7b, 7'h6b, 7'h4f, 7'h7d, 7'h7d, 7'h7d};
    always #5 clk_sys = ~clk_sys;
    pmrw_top #(.WDT_IRQ_CYCLES(WIRQ), .WDT_RST_CYCLES(WRST), .SETTLE_CYCLES(SETL)) dut_u (.clk_sys(clk_sys),
        .rst(rst), .battery_ok(battery_ok), .ext_reset_n(ext_reset_n), .buck_good(buck_good),
        .ldo_good(ldo_good), .mode_req(mode_req), .mode_req_valid(mode_req_valid),
        .wake_interval(wake_interval), .io_wake(io_wake), .wdt_service(wdt_service),
        .wdt_irq_clear(wdt_irq_clear), .lf_select(lf_select), .lf_lowpwr_clk(lf_lowpwr_clk),
        .lf_accurate_clk(lf_accurate_clk), .lf_extxtal_clk(lf_extxtal_clk),
        .fw_debug_enable(fw_debug_enable), .lockout_present(lockout_present), .raw_read_req(raw_read_req),
        .mode(mode), .cpu_run(cpu_run), .periph_en(periph_en), .hclk_en(hclk_en), .radio_pwr(radio_pwr),
        .core_pwr(core_pwr), .retain_pwr(retain_pwr), .ldo_low_v(ldo_low_v), .low_freq_clock(low_freq_clock),
        .lf_osc_en(lf_osc_en), .buck_en(buck_en), .rf_ldo_en(rf_ldo_en), .dig_ldo_en(dig_ldo_en),
        .core_reset(core_reset), .wdt_irq(wdt_irq), .wdt_reset(wdt_reset), .debug_access(debug_access),
        .raw_read_grant(raw_read_grant), .raw_read_reject(raw_read_reject), .wake_cause(wake_cause),
        .woke_from_off(woke_from_off));
    pmrw_partner partner_u (.clk_sys(clk_sys), .buck_en(buck_en), .rf_ldo_en(rf_ldo_en),
        .dig_ldo_en(dig_ldo_en), .lf_osc_en(lf_osc_en), .buck_good(buck_good), .ldo_good(ldo_good),
        .lf_lowpwr_clk(lf_lowpwr_clk), .lf_accurate_clk(lf_accurate_clk), .lf_extxtal_clk(lf_extxtal_clk));
    // ****************************************
    // Background firmware service, one driver for the pulse
    // ****************************************
    always @(negedge clk_sys) begin
        cyc <= cyc + 1;
        wdt_service <= svc_now || (svc_en && (cyc % 50 == 0));
    end
    always @(posedge clk_sys) lgc <= (ldo_good === 1'b1) ? lgc + 1 : 0;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic final_report();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    function automatic logic sel(input int w);
        case (w)
            0: return buck_en;
            1: return rf_ldo_en;
            2: return core_reset;
            3: return mode === 3'h0;
            4: return wdt_irq;
            5: return wdt_reset;
            default: return ~core_reset;
        endcase
    endfunction
    // Bounded wait; a hang is a mismatch and ends the run
    task automatic wait_hi(input int w, input int lim, output int k);
        k = 0;
        while (sel(w) !== 1'b1) begin
            if (k >= lim) begin
                num_errors++;
                $display("[FAIL] %0t wait %0d timed out", $time, w);
                final_report();
            end
            tick(1);
            k++;
        end
    endtask
    task automatic req(input int m);
        mode_req = m[2:0];
        mode_req_valid = 1'b1;
        tick(1);
        mode_req_valid = 1'b0;
        tick(1);
        if (exp_mode < 2 && m <= 5) exp_mode = m;
        chk(mode, exp_mode, "mode after request");
    endtask
    task automatic chk_pwr();
        chk({cpu_run, periph_en, radio_pwr, core_pwr, retain_pwr, ldo_low_v, lf_osc_en} & pmsk[exp_mode],
            pexp[exp_mode], "power outputs");
    endtask
    task automatic cnt_hclk(input int len, output int c);
        c = 0;
        repeat (len) begin
            tick(1);
            c += (hclk_en === 1'b1);
        end
    endtask
    task automatic power_up();
        wait_hi(0, 50, n);
        chk(rf_ldo_en | dig_ldo_en, 0, "ldo before buck");
        wait_hi(1, 50, n);
        chk({buck_en, dig_ldo_en}, 2'h3, "ldo enables");
        wait_hi(6, 100, n);
        chk(lgc >= SETL, 1, "core released early");
        chk(debug_access, 0, "debug after power-up");
        exp_mode = 0;
        chk(mode, 0, "mode after power-up");
    endtask
    initial begin
        #900000;
        num_errors++;
        $display("[FAIL] %0t global timeout", $time);
        final_report();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        tick(3);
        rst = 1'b0;
        tick(2);
        chk({core_reset, buck_en}, 2'h2, "held without battery");
        battery_ok = 1'b1;
        tick(2);
        ext_reset_n = 1'b1;
        power_up();
        tick(50);
        chk(mode, 0, "no autonomous change");
        req(6);
        req(1);
        chk_pwr();
        cnt_hclk(64, n);
        chk(n, 64 / pmrw_pkg::HCLK_DIV_IDLE, "idle bus clock");
        req(0);
        chk_pwr();
        cnt_hclk(64, n);
        chk(n, 64, "active bus clock");
        for (int k = 0; k < 6; k++) begin
            // Interval of 4 or more, so the timer cannot fire before the refused request is seen
            iv = 4 + ($random(seed) & 7);
            wake_interval = (k < 3) ? 8'hff : iv[7:0];
            req(2 + k % 3);
            chk_pwr();
            cnt_hclk(16, n);
            chk(n, 0, "bus clock asleep");
            req(0);
            if (k < 3) begin
                tick($random(seed) & 7);
                io_wake = 1'b1;
                tick(1);
                chk(mode, exp_mode, "wake before sync");
            end
            wait_hi(3, 300, n);
            io_wake = 1'b0;
            exp_mode = 0;
            chk(wake_cause, (k < 3) ? pmrw_pkg::WAKE_IO : pmrw_pkg::WAKE_TIMER, "wake cause");
            if (k >= 3) chk(n + 18 >= (iv - 1) * 8 && n + 19 <= iv * 8, 1, "timer wake time");
            // Latched wake level only clears on the next slow edge
            tick(12);
        end
        req(5);
        chk_pwr();
        io_wake = 1'b1;
        wait_hi(2, 300, n);
        wait_hi(6, 500, n);
        io_wake = 1'b0;
        wait_hi(3, 50, n);
        exp_mode = 0;
        chk({woke_from_off, wake_cause}, {1'b1, pmrw_pkg::WAKE_IO}, "deep-off record");
        for (int s = 0; s < 3; s++) begin
            lf_select = s[1:0];
            tick(4);
            n = 0;
            repeat (240) begin
                n2 = low_freq_clock;
                tick(1);
                n += (n2 == 0 && low_freq_clock === 1'b1);
            end
            chk(n >= edges[s] - 1 && n <= edges[s] + 1, 1, "slow clock source");
        end
        fw_debug_enable = 1'b1;
        tick(2);
        chk(debug_access, 1, "debug enabled");
        lockout_present = 1'b1;
        raw_read_req = 1'b1;
        tick(2);
        chk({debug_access, raw_read_grant, raw_read_reject}, 3'h1, "lockout");
        lockout_present = 1'b0;
        tick(2);
        chk({raw_read_grant, raw_read_reject}, 2'h2, "raw read granted");
        svc_en = 0;
        svc_now = 1;
        tick(2);
        svc_now = 0;
        wait_hi(4, WIRQ + 20, n);
        chk(n >= WIRQ - 3 && n <= WIRQ + 3, 1, "watchdog interrupt time");
        wdt_irq_clear = 1'b1;
        tick(1);
        wdt_irq_clear = 1'b0;
        tick(1);
        chk(wdt_irq, 0, "interrupt cleared");
        wait_hi(5, WRST, n2);
        chk(n + n2 + 2 >= WRST - 4 && n + n2 + 2 <= WRST + 4, 1, "watchdog reset time");
        tick(1);
        chk({core_reset, wake_cause}, {1'b1, pmrw_pkg::WAKE_WDT}, "watchdog reset");
        svc_en = 1;
        wait_hi(6, 200, n);
        ext_reset_n = 1'b0;
        tick(3);
        chk({core_reset, buck_en}, 2'h2, "external reset");
        ext_reset_n = 1'b1;
        power_up();
        final_report();
    end
endmodule
